// [spwm_pkg.sv]
/*
 Constants for the four-channel standard PWM block: register map, field layout,
 reset values, mode codes and timing figures.
 Assumes a 25 MHz APB clock; included by every module of the block except spwm_load.
*/
package spwm_pkg;
    localparam int NUM_CHAN = 4;
    localparam int ADDR_W = 8;
    // Register byte addresses
    localparam logic [7:0] OFS_REMAP_ZERO = 8'h00;
    localparam logic [7:0] OFS_REMAP_ONE = 8'h04;
    localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h08;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h0C;
    localparam logic [7:0] OFS_TIMER_COUNT = 8'h10;
    localparam logic [7:0] OFS_PIN_DIR = 8'h14;
    localparam logic [7:0] OFS_CHAN_BASE = 8'h20;
    localparam logic [7:0] CHAN_STRIDE = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DUTY_MSB = 8'h04;
    localparam logic [7:0] OFS_DUTY_SHADOW = 8'h08;
    // Control register fields
    localparam int MODE_LSB = 0;
    localparam int DUTY_LOW_LSB = 4;
    localparam int STEER_LSB = 6;
    localparam logic [3:0] MODE_PWM_MASK = 4'hC;
    // Timer control fields
    localparam int TMR_PRESC_LSB = 0;
    localparam int TMR_ON_BIT = 2;
    localparam logic [1:0] PRESC_1 = 2'h0;
    localparam logic [1:0] PRESC_4 = 2'h1;
    // Reset values
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PIN_DIR = 8'h0F;
    // Plain channels have no steering field
    localparam logic [7:0] CTRL_MASK_ENH = 8'hFF;
    localparam logic [7:0] CTRL_MASK_PLAIN = 8'h3F;
    // System clock phases per timer increment at 1:1
    localparam int CLK_PER_INC = 4;
endpackage : spwm_pkg

// [spwm_channel.sv]
/*
 One standard PWM channel: duty double buffer and 10-bit comparator.
 Assumes the time base and the period match pulse come from a shared timer.
*/
`timescale 1ns/10ps
`default_nettype none
module spwm_channel
    import spwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] ctrl,
    input wire logic [7:0] duty_msb,
    input wire logic [9:0] time_base,
    input wire logic step,
    input wire logic period_end,
    output logic [7:0] shadow,
    output logic pwm_level,
    output logic active
);
    logic [1:0] shadow_low;
    logic level;
    logic [7:0] next_shadow;
    logic [1:0] next_shadow_low;
    logic next_level;
    logic [9:0] duty_full;
    logic pwm_mode;

    always_comb begin
        pwm_mode = (ctrl[MODE_LSB +: 4] & MODE_PWM_MASK) == MODE_PWM_MASK;
        duty_full = {duty_msb, ctrl[DUTY_LOW_LSB +: 2]};
        next_shadow = shadow;
        next_shadow_low = shadow_low;
        next_level = level;
        if (ctrl == RST_ZERO) begin
            next_level = 1'b0;
        end else if (pwm_mode && step) begin
            if (period_end) begin
                next_shadow = duty_full[9:2];
                next_shadow_low = duty_full[1:0];
                next_level = (duty_full != 10'h000);
            end else if (time_base == {shadow, shadow_low}) begin
                next_level = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow <= RST_ZERO;
            shadow_low <= 2'h0;
            level <= 1'b0;
        end else begin
            shadow <= next_shadow;
            shadow_low <= next_shadow_low;
            level <= next_level;
        end
    end

    assign pwm_level = level;
    assign active = pwm_mode;
endmodule : spwm_channel
`default_nettype wire

// [spwm_top.sv]
/*
 Four standard PWM channels with a shared 8-bit period timer, APB register slave,
 pin direction and pin remap. Assumes an APB master on pclk and pad logic outside
 that resolves the two pin locations per channel from the enables.
*/
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module spwm_top
    import spwm_pkg::*;
#(
    parameter int N = NUM_CHAN
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [N-1:0] pin_out_main,
    output logic [N-1:0] pin_oe_main,
    output logic [N-1:0] pin_out_alt,
    output logic [N-1:0] pin_oe_alt
);
    logic [7:0] remap_zero;
    logic [7:0] remap_one;
    logic [7:0] period_limit_reg;
    logic [7:0] period_timer_control;
    logic [7:0] period_timer_count;
    logic [7:0] pin_direction;
    logic [7:0] channel_control_reg [N];
    logic [7:0] duty_msb_reg [N];
    logic [7:0] duty_shadow_reg [N];
    logic [N-1:0] lvl;
    logic [N-1:0] act;
    logic [3:0] presc;
    logic [7:0] next_count;
    logic [3:0] next_presc;
    logic step;
    logic period_end;
    logic [1:0] low_bits;
    logic [9:0] time_base;
    logic wr;
    logic rd;
    logic [31:0] next_prdata;
    logic next_err;
    logic [N-1:0] next_out_main;
    logic [N-1:0] next_oe_main;
    logic [N-1:0] next_out_alt;
    logic [N-1:0] next_oe_alt;
    logic [3:0] presc_limit;

    // Shared period timer; prescaler counts system clocks per increment
    always_comb begin
        unique case (period_timer_control[TMR_PRESC_LSB +: 2])
            PRESC_1: presc_limit = 4'(CLK_PER_INC - 1);
            PRESC_4: presc_limit = 4'hF;
            default: presc_limit = 4'hF;
        endcase
        next_presc = presc;
        next_count = period_timer_count;
        step = 1'b0;
        if (period_timer_control[TMR_ON_BIT]) begin
            if (presc >= presc_limit) begin
                next_presc = 4'h0;
                step = 1'b1;
            end else begin
                next_presc = 4'(presc + 4'h1);
            end
        end
        period_end = step && (period_timer_count == period_limit_reg);
        if (step) begin
            next_count = period_end ? 8'h00 : 8'(period_timer_count + 8'h01);
        end
        // Coming cycle's time base, so the registered level falls on the match itself
        low_bits = (period_timer_control[TMR_PRESC_LSB +: 2] == PRESC_1) ? next_presc[1:0] : next_presc[3:2];
        time_base = {next_count, low_bits};
    end

    // Comparison runs on every clock so sub-increment steps resolve
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chan
            spwm_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .ctrl(channel_control_reg[g]),
                .duty_msb(duty_msb_reg[g]),
                .time_base(time_base),
                .step(1'b1),
                .period_end(period_end),
                .shadow(duty_shadow_reg[g]),
                .pwm_level(lvl[g]),
                .active(act[g])
            );
        end
    endgenerate

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remap_zero <= RST_ZERO;
            remap_one <= RST_ZERO;
            period_limit_reg <= RST_PERIOD;
            period_timer_control <= RST_ZERO;
            pin_direction <= RST_PIN_DIR;
            for (int i = 0; i < N; i++) begin
                channel_control_reg[i] <= RST_ZERO;
                duty_msb_reg[i] <= RST_ZERO;
            end
        end else if (wr) begin
            unique case (paddr)
                OFS_REMAP_ZERO: remap_zero <= pwdata[7:0];
                OFS_REMAP_ONE: remap_one <= pwdata[7:0];
                OFS_PERIOD_LIMIT: period_limit_reg <= pwdata[7:0];
                OFS_TIMER_CTRL: period_timer_control <= pwdata[7:0] & 8'h07;
                OFS_PIN_DIR: pin_direction <= pwdata[7:0] & 8'h0F;
                default: begin
                    for (int i = 0; i < N; i++) begin
                        if (paddr == 8'(OFS_CHAN_BASE + 8'(i) * CHAN_STRIDE + OFS_CTRL)) begin
                            channel_control_reg[i] <= pwdata[7:0] & ((i < 2) ? CTRL_MASK_ENH : CTRL_MASK_PLAIN);
                        end
                        if (paddr == 8'(OFS_CHAN_BASE + 8'(i) * CHAN_STRIDE + OFS_DUTY_MSB)) begin
                            duty_msb_reg[i] <= pwdata[7:0];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_timer_count <= RST_ZERO;
            presc <= 4'h0;
        end else begin
            period_timer_count <= next_count;
            presc <= next_presc;
        end
    end

    // Read data, error and pin drive
    always_comb begin
        next_prdata = prdata;
        next_err = 1'b0;
        if (rd) begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                OFS_REMAP_ZERO: next_prdata[7:0] = remap_zero;
                OFS_REMAP_ONE: next_prdata[7:0] = remap_one;
                OFS_PERIOD_LIMIT: next_prdata[7:0] = period_limit_reg;
                OFS_TIMER_CTRL: next_prdata[7:0] = period_timer_control;
                OFS_TIMER_COUNT: next_prdata[7:0] = period_timer_count;
                OFS_PIN_DIR: next_prdata[7:0] = pin_direction;
                default: begin
                    next_err = 1'b1;
                    for (int i = 0; i < N; i++) begin
                        if (paddr == 8'(OFS_CHAN_BASE + 8'(i) * CHAN_STRIDE + OFS_CTRL)) begin
                            next_prdata[7:0] = channel_control_reg[i];
                            next_err = 1'b0;
                        end
                        if (paddr == 8'(OFS_CHAN_BASE + 8'(i) * CHAN_STRIDE + OFS_DUTY_MSB)) begin
                            next_prdata[7:0] = duty_msb_reg[i];
                            next_err = 1'b0;
                        end
                        if (paddr == 8'(OFS_CHAN_BASE + 8'(i) * CHAN_STRIDE + OFS_DUTY_SHADOW)) begin
                            next_prdata[7:0] = duty_shadow_reg[i];
                            next_err = 1'b0;
                        end
                    end
                end
            endcase
        end else if (psel && !penable) begin
            // Write decode checked in setup; shadow is read-only
            next_err = 1'b1;
            unique case (paddr)
                OFS_REMAP_ZERO, OFS_REMAP_ONE, OFS_PERIOD_LIMIT, OFS_TIMER_CTRL, OFS_PIN_DIR: next_err = 1'b0;
                default: begin
                    for (int i = 0; i < N; i++) begin
                        if (paddr == 8'(OFS_CHAN_BASE + 8'(i) * CHAN_STRIDE + OFS_CTRL) ||
                            paddr == 8'(OFS_CHAN_BASE + 8'(i) * CHAN_STRIDE + OFS_DUTY_MSB)) begin
                            next_err = 1'b0;
                        end
                    end
                end
            endcase
        end
        for (int i = 0; i < N; i++) begin
            // Drive only in PWM mode with direction cleared
            next_out_main[i] = lvl[i] & ~remap_zero[i];
            next_oe_main[i] = act[i] & ~pin_direction[i] & ~remap_zero[i];
            next_out_alt[i] = lvl[i] & remap_zero[i];
            next_oe_alt[i] = act[i] & ~pin_direction[i] & remap_zero[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pin_out_main <= '0;
            pin_oe_main <= '0;
            pin_out_alt <= '0;
            pin_oe_alt <= '0;
        end else begin
            prdata <= next_prdata;
            pready <= psel && !penable;
            pslverr <= next_err;
            pin_out_main <= next_out_main;
            pin_oe_main <= next_oe_main;
            pin_out_alt <= next_out_alt;
            pin_oe_alt <= next_oe_alt;
        end
    end
endmodule : spwm_top
`default_nettype wire

// [spwm_sva.sv]
/*
 Port checker for the four-channel PWM block.
 Assumes spwm_pkg is compiled first and binds to every spwm_top.
*/
`timescale 1ns/10ps
`default_nettype none
module spwm_sva
    import spwm_pkg::*;
#(
    parameter int N = NUM_CHAN
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [N-1:0] pin_out_main,
    input wire logic [N-1:0] pin_oe_main,
    input wire logic [N-1:0] pin_out_alt,
    input wire logic [N-1:0] pin_oe_alt
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc_wr;
    assign acc_wr = psel && penable && pready && pwrite;
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error outside access");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_unmapped_read: assert property (psel && !penable && !pwrite && paddr == 8'h1C |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_shadow_ro: assert property (psel && !penable && pwrite && paddr == 8'h28 |=> pslverr)
        else $error("shadow write not refused");
    a_pin_exclusive: assert property ((pin_oe_main & pin_oe_alt) == '0)
        else $error("both pin locations driven");
    a_ctrl_zero_release: assert property (acc_wr && paddr == OFS_CHAN_BASE && pwdata[7:0] == 8'h00
        |-> ##[1:4] (!pin_oe_main[0] && !pin_oe_alt[0] && !pin_out_main[0]))
        else $error("pin kept after control cleared");
    a_remap_alt: assert property (acc_wr && paddr == OFS_REMAP_ZERO && pwdata[0] |-> ##[1:4] !pin_oe_main[0])
        else $error("default pin still driven");
    a_dir_input: assert property (acc_wr && paddr == OFS_PIN_DIR && pwdata[0]
        |-> ##[1:4] !(pin_oe_main[0] || pin_oe_alt[0]))
        else $error("pin driven while input");
    cover property (pslverr);
    cover property ($rose(pin_out_main[0]));
    cover property (|pin_oe_alt);
endmodule : spwm_sva
bind spwm_top spwm_sva #(.N(N)) i_spwm_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_out_main(pin_out_main), .pin_oe_main(pin_oe_main), .pin_out_alt(pin_out_alt), .pin_oe_alt(pin_oe_alt));
`default_nettype wire

// [spwm_load.sv]
/*
 Load on the channel pins, pulled down when released.
 Assumes pad resolution from level and enable only.
*/
`timescale 1ns/10ps
`default_nettype none
module spwm_load #(
    parameter int N = 4
)
(
    input wire logic [N-1:0] out_main,
    input wire logic [N-1:0] oe_main,
    input wire logic [N-1:0] out_alt,
    input wire logic [N-1:0] oe_alt,
    output logic [N-1:0] lvl_main,
    output logic [N-1:0] lvl_alt
);
    // Pull-down, so a released pin never shows a stale high
    assign lvl_main = out_main & oe_main;
    assign lvl_alt = out_alt & oe_alt;
endmodule : spwm_load
`default_nettype wire

// [tb.sv]
/*
 Self-checking bench for spwm_top: registers, refusals, duty waveforms, pin control.
 Assumes spwm_pkg, spwm_load and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    import spwm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, a;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] out_m, oe_m, out_a, oe_a, lvl_m, lvl_a;
    logic [9:0] duty [4];
    logic [7:0] ra [6] = '{OFS_PERIOD_LIMIT, OFS_PIN_DIR, OFS_TIMER_CTRL, OFS_REMAP_ZERO, 8'h20, 8'h50};
    logic [7:0] re [6] = '{8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
    int err_count, n_compared, m, ps;
    int cnt [4];
    spwm_top i_spwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_out_main(out_m), .pin_oe_main(oe_m), .pin_out_alt(out_a), .pin_oe_alt(oe_a));
    spwm_load i_spwm_load (.out_main(out_m), .oe_main(oe_m), .out_alt(out_a), .oe_alt(oe_a),
        .lvl_main(lvl_m), .lvl_alt(lvl_a));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Entered just after a rising edge; ends on one, bus idle
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        @(posedge pclk);
    endtask : apb
    function automatic int exp_high(input logic [9:0] d, input int mul);
        return (d > 10'd16 ? 16 : int'(d)) * mul;
    endfunction : exp_high
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_count = 0;
        n_compared = 0;
        void'($urandom(73925));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, {24'h0, re[i]});
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h28, 32'h55);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 8'h40, 32'hFFFFFFFF);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h3F);
        apb(1'b1, OFS_PIN_DIR, 32'h0);
        apb(1'b1, OFS_PERIOD_LIMIT, 32'h3);
        for (int it = 0; it < 8; it++) begin
            ps = (it < 2) ? it : $urandom_range(1, 0);
            m = ps ? 4 : 1;
            apb(1'b1, OFS_TIMER_CTRL, {29'h0, 1'b1, 1'b0, ps[0]});
            for (int c = 0; c < 4; c++) begin
                duty[c] = (it == 0) ? 10'(c * 7 - (c == 1 ? -9 : 0) + (c == 2 ? 6 : 0)) : 10'($urandom_range(19, 0));
                a = OFS_CHAN_BASE + CHAN_STRIDE * 8'(c);
                apb(1'b1, a + OFS_DUTY_MSB, {24'h0, duty[c][9:2]});
                apb(1'b1, a, {26'h0, duty[c][1:0], 4'hC});
            end
            repeat (48 * m) @(posedge pclk);
            cnt = '{default: 0};
            repeat (16 * m) begin
                @(posedge pclk);
                for (int c = 0; c < 4; c++) cnt[c] += int'(lvl_m[c]);
            end
            for (int c = 0; c < 4; c++) begin
                chk(32'(cnt[c]), 32'(exp_high(duty[c], m)));
                apb(1'b0, OFS_CHAN_BASE + CHAN_STRIDE * 8'(c) + OFS_DUTY_SHADOW, 32'h0);
                chk(rd, {24'h0, duty[c][9:2]});
            end
            chk({28'h0, oe_m}, 32'hF);
        end
        apb(1'b1, OFS_REMAP_ZERO, 32'h5);
        repeat (4) @(posedge pclk);
        chk({24'h0, oe_a, oe_m}, 32'h5A);
        // Moved channels must carry the same waveform on the alternate pin
        cnt = '{default: 0};
        repeat (16 * m) begin
            @(posedge pclk);
            for (int c = 0; c < 4; c++) cnt[c] += int'(lvl_a[c]);
        end
        for (int c = 0; c < 4; c++) begin
            chk(32'(cnt[c]), (c % 2 == 1) ? 32'h0 : 32'(exp_high(duty[c], m)));
        end
        apb(1'b1, OFS_PIN_DIR, 32'h3);
        repeat (4) @(posedge pclk);
        chk({24'h0, oe_a, oe_m}, 32'h48);
        apb(1'b1, OFS_REMAP_ZERO, 32'h0);
        apb(1'b1, OFS_PIN_DIR, 32'h0);
        apb(1'b1, OFS_CHAN_BASE, 32'h0);
        repeat (4) @(posedge pclk);
        chk({24'h0, oe_m, out_m[0], oe_a[0], 2'b00}, 32'hE0);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_PERIOD_LIMIT, 32'h0);
        chk({oe_m, rd[27:0]}, 32'hFF);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
